// [design/bram_port_b.sv]
// Purpose: Port B of a dual-port block memory, one clock, fabric facing.
// Assumes: All inputs come from fabric logic on ref_clk; Port A is absent.
// Notes: Depth of Port B follows from Port A size and the width ratio.
// Notes: Configuration is fixed per instance; every mode is a parameter.
// Notes: Checks sit beside the logic and run on the selected edge.
// Notes: Memory contents are never cleared; fill before reading.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Port access read, write or both, independently.
// - Width ratio power of two, at most 32.
// - Depth equals reachable words at port width.
// - No-change mode holds read output during writes.
// - Write-first mode shows written data on output.
// - Clock edge selectable, rising or falling.
// - Port enable polarity selectable; driver stays active-high, bench inverts it.
// - Output latch has synchronous reset, selectable polarity.
// - Output register adds one cycle read latency.
// - Reset priority: reset ignores clock enable.
// - Enable priority: reset needs clock enable high.
// - Output register synchronous reset, selectable polarity.
// - Capacity equals Port A depth times width.
module bram_port_b
  import bram_port_b_pkg::*;
#(
  parameter int WIDTH_A = 32,
  parameter int DEPTH_A = 512,
  parameter int WIDTH_B = 8,
  parameter port_cfg_t CFG = CFG_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Access request
  input wire logic port_en,
  input wire logic wr_en,
  input wire logic [$clog2((DEPTH_A * WIDTH_A) / WIDTH_B)-1:0] addr,
  input wire logic [WIDTH_B-1:0] wr_data,
  // Output stage controls
  input wire logic latch_rst,
  input wire logic outreg_ce,
  input wire logic outreg_rst,
  // Read data
  output logic [WIDTH_B-1:0] rd_data
);

  // Storage sized from Port A so both ports see the same bits
  // A bad width pair is caught by a check, not rounded silently
  localparam int TOTAL_BITS = DEPTH_A * WIDTH_A;
  localparam int DEPTH_B = TOTAL_BITS / WIDTH_B;
  localparam int AW = $clog2(DEPTH_B);
  // A ratio is legal only as a power of two within the limit
  localparam int RATIO = (WIDTH_A > WIDTH_B) ? WIDTH_A / WIDTH_B : WIDTH_B / WIDTH_A;
  localparam int WIDE = (WIDTH_A > WIDTH_B) ? WIDTH_A : WIDTH_B;
  localparam int NARROW = (WIDTH_A > WIDTH_B) ? WIDTH_B : WIDTH_A;
  localparam bit RATIO_OK = (RATIO * NARROW == WIDE) && (RATIO <= MAX_RATIO)
    && ((RATIO & (RATIO - 1)) == 0);
  localparam logic [WIDTH_B-1:0] RST_WORD = {WIDTH_B{RESET_BIT}};

  // Selected active edge; an inverted clock keeps one domain
  // Falling-edge use halves the time the fabric has to settle
  logic act_clk;
  assign act_clk = CFG.clk_rising ? ref_clk : ~ref_clk;

  // Decoded controls at their configured polarity
  // Polarity is folded in here so the rest sees active-high
  logic pe_on;
  logic lrst_on;
  logic orst_on;
  logic can_wr;
  logic can_rd;
  logic do_wr;
  logic do_rd;
  assign pe_on = (port_en == CFG.pe_high);
  assign lrst_on = (latch_rst == CFG.latch_rst_high);
  assign orst_on = (outreg_rst == CFG.outreg_rst_high);
  assign can_wr = (CFG.access != ACC_READ_ONLY);
  assign can_rd = (CFG.access != ACC_WRITE_ONLY);
  assign do_wr = pe_on && wr_en && can_wr;
  // A read-only port treats any enabled cycle as a read
  assign do_rd = pe_on && can_rd && !(wr_en && can_wr);

  // Memory array; contents survive reset, as in a real block memory
  // Read is combinational here and registered by the latch stage
  logic [WIDTH_B-1:0] mem [DEPTH_B];
  logic [WIDTH_B-1:0] rd_word;
  assign rd_word = mem[addr];

  // Array write port
  always_ff @(posedge act_clk) begin
    if (do_wr) begin
      mem[addr] <= wr_data;
    end
  end

  // Output latch and output register
  logic [WIDTH_B-1:0] latch_ff;
  logic [WIDTH_B-1:0] nxt_latch;
  logic [WIDTH_B-1:0] oreg_ff;
  logic [WIDTH_B-1:0] nxt_oreg;
  logic [WIDTH_B-1:0] rd_data_ff;
  logic [WIDTH_B-1:0] nxt_rd_data;

  // Latch next value: reset, then read, then write-mode behaviour
  // Reset wins so a stale word never leaks after a clear
  always_comb begin
    nxt_latch = latch_ff;
    if (lrst_on) begin
      nxt_latch = RST_WORD;
    end else if (do_rd) begin
      nxt_latch = rd_word;
    end else if (do_wr && CFG.wmode == WM_WRITE_FIRST) begin
      nxt_latch = wr_data;
    end else begin
      nxt_latch = latch_ff;
    end
  end

  // Output register next value; priority picks who gates the reset
  // Register always loads from the latch, never from the array
  always_comb begin
    nxt_oreg = oreg_ff;
    if (CFG.prio == PRIO_RSTREG && orst_on) begin
      nxt_oreg = RST_WORD;
    end else if (outreg_ce) begin
      // Under enable priority the reset only acts with the enable high
      nxt_oreg = orst_on ? RST_WORD : latch_ff;
    end
  end

  // Read data source; output flop carries the selected stage's next value
  always_comb begin
    nxt_rd_data = CFG.outreg_en ? nxt_oreg : nxt_latch;
  end

  // Registers only; the output flop mirrors the selected stage
  // Costs one extra word of flops for a clean registered output
  always_ff @(posedge act_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_ff <= '0;
      oreg_ff <= '0;
      rd_data_ff <= '0;
    end else begin
      latch_ff <= nxt_latch;
      oreg_ff <= nxt_oreg;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

  // Checks on the selected clock edge
  default clocking dflt_cb @(posedge act_clk);
  endclocking
  default disable iff (!reset_n);

  a_width_ratio: assert property (RATIO_OK)
    else $error("port width ratio not a legal power of two");

  a_depth_cover: assert property (DEPTH_B * WIDTH_B == TOTAL_BITS)
    else $error("port depth does not cover total storage");

  a_read_only: assert property (!can_wr |-> !do_wr)
    else $error("write taken on a read-only port");

  a_bypass_read: assert property (
    (do_rd && !lrst_on && !CFG.outreg_en) |=> rd_data == $past(rd_word))
    else $error("bypassed read data not one edge after address");

  a_nochange_hold: assert property (
    (CFG.wmode == WM_NO_CHANGE && do_wr && !lrst_on) |=> $stable(latch_ff))
    else $error("read output moved during a no-change write");

  a_write_first: assert property (
    (CFG.wmode == WM_WRITE_FIRST && do_wr && !lrst_on)
    |=> latch_ff == $past(wr_data))
    else $error("written data not shown in write-first mode");

  a_latch_reset: assert property (lrst_on |=> latch_ff == RST_WORD)
    else $error("output latch not cleared by its reset");

  a_outreg_latency: assert property (
    (CFG.outreg_en && do_rd && !lrst_on) ##1 (outreg_ce && !orst_on)
    |=> rd_data == $past(rd_word, 2))
    else $error("registered read not two edges after address");

  a_rst_priority: assert property (
    (CFG.prio == PRIO_RSTREG && orst_on) |=> oreg_ff == RST_WORD)
    else $error("reset priority did not clear output register");

  a_ce_gates_rst: assert property (
    (CFG.prio == PRIO_REGCE && orst_on && !outreg_ce) |=> $stable(oreg_ff))
    else $error("output register moved without its enable");

  a_ce_rst_acts: assert property (
    (orst_on && outreg_ce) |=> oreg_ff == RST_WORD)
    else $error("output register not reset with enable high");

  a_out_follows: assert property (
    CFG.outreg_en |-> rd_data == oreg_ff)
    else $error("read data not from output register");

  // Port access and enable gating
  // Direction and enable decide which operation an edge takes
  a_write_only: assert property (!can_rd |-> !do_rd)
    else $error("read taken on a write-only port");

  a_one_op: assert property (!(do_rd && do_wr))
    else $error("read and write taken on one edge");

  a_ro_reads: assert property (
    (CFG.access == ACC_READ_ONLY && pe_on) |-> do_rd)
    else $error("enabled cycle ignored on a read-only port");

  a_mem_store: assert property (
    do_wr |=> mem[$past(addr)] == $past(wr_data))
    else $error("write data not stored at its address");

  a_addr_range: assert property (pe_on |-> addr < DEPTH_B)
    else $error("address beyond the port depth");

  a_ratio_bound: assert property (RATIO <= MAX_RATIO)
    else $error("port width ratio above the limit");

  a_disabled_nowr: assert property (!pe_on |-> !do_wr)
    else $error("write taken with the port disabled");

  a_disabled_hold: assert property (
    (!pe_on && !lrst_on) |=> $stable(latch_ff))
    else $error("latch moved with the port disabled");

  // Read output behaviour without the output register
  // Here the read data must track the latch edge for edge
  a_bypass_mirror: assert property (!CFG.outreg_en |-> rd_data == latch_ff)
    else $error("bypassed read data not from the latch");

  a_nochange_out: assert property (
    (CFG.wmode == WM_NO_CHANGE && do_wr && !lrst_on && !CFG.outreg_en)
    |=> $stable(rd_data))
    else $error("read data moved during a no-change write");

  a_wf_output: assert property (
    (CFG.wmode == WM_WRITE_FIRST && do_wr && !lrst_on && !CFG.outreg_en)
    |=> rd_data == $past(wr_data))
    else $error("write-first data not on read output");

  a_wf_matches: assert property (
    (CFG.wmode == WM_WRITE_FIRST && do_wr && !lrst_on)
    |=> latch_ff == mem[$past(addr)])
    else $error("write-first output differs from stored word");

  // Output register loading and reset priority
  // Priority only matters when reset comes with the enable low
  a_outreg_load: assert property (
    (outreg_ce && !orst_on) |=> oreg_ff == $past(latch_ff))
    else $error("output register did not load the latch");

  a_outreg_hold: assert property (
    (!outreg_ce && !(CFG.prio == PRIO_RSTREG && orst_on)) |=> $stable(oreg_ff))
    else $error("output register moved without its enable");

  a_rst_no_ce: assert property (
    (CFG.prio == PRIO_RSTREG && orst_on && !outreg_ce) |=> oreg_ff == RST_WORD)
    else $error("reset priority needed the enable");

  a_regce_rst: assert property (
    (CFG.prio == PRIO_REGCE && orst_on && outreg_ce) |=> oreg_ff == RST_WORD)
    else $error("enable priority reset did not act");

  // Output register path seen at the read data
  // a_reg_out_hold, a_bypass_rst and a_reg_rst_out watch the pin; the others watch latch_ff or the ratio
  a_reg_out_hold: assert property (
    (CFG.outreg_en && !outreg_ce && !orst_on) |=> $stable(rd_data))
    else $error("registered read data moved without enable");

  a_latch_idle: assert property (
    (!do_rd && !do_wr && !lrst_on) |=> $stable(latch_ff))
    else $error("latch moved with no operation");

  a_wo_latch: assert property (
    (!can_rd && CFG.wmode == WM_NO_CHANGE && !lrst_on) |=> $stable(latch_ff))
    else $error("latch moved on a write-only port");

  a_latch_rd_rst: assert property (
    (lrst_on && do_rd) |=> latch_ff == RST_WORD)
    else $error("read data won over the latch reset");

  a_ratio_pow2: assert property ((RATIO & (RATIO - 1)) == 0)
    else $error("port width ratio not a power of two");

  a_bypass_rst: assert property (
    (lrst_on && !CFG.outreg_en) |=> rd_data == RST_WORD)
    else $error("bypassed read data not cleared by latch reset");

  a_reg_rst_out: assert property (
    (CFG.outreg_en && orst_on && outreg_ce) |=> rd_data == RST_WORD)
    else $error("registered read data not cleared by its reset");

endmodule
`default_nettype wire

// [common/bram_port_b_pkg.sv]
// Purpose: Shared types and constants for the Port B memory port.
// Assumes: One clock, fabric-side inputs on that clock.
// Notes: Configuration travels as one packed struct parameter.
package bram_port_b_pkg;

  // Access direction of the port
  typedef enum logic [1:0] {
    ACC_READ_ONLY  = 2'b00,
    ACC_WRITE_ONLY = 2'b01,
    ACC_READ_WRITE = 2'b10
  } access_mode_t;

  // What the read output shows during a write
  typedef enum logic {
    WM_NO_CHANGE   = 1'b0,
    WM_WRITE_FIRST = 1'b1
  } write_mode_t;

  // Which input wins at the output register
  typedef enum logic {
    PRIO_RSTREG = 1'b0,
    PRIO_REGCE  = 1'b1
  } ce_prio_t;

  // Per-instance configuration
  typedef struct packed {
    access_mode_t access;
    write_mode_t wmode;
    logic clk_rising;
    logic pe_high;
    logic latch_rst_high;
    logic outreg_en;
    ce_prio_t prio;
    logic outreg_rst_high;
  } port_cfg_t;

  // Documented default configuration
  localparam port_cfg_t CFG_DEFAULT = '{
    access: ACC_READ_WRITE,
    wmode: WM_NO_CHANGE,
    clk_rising: 1'b1,
    pe_high: 1'b1,
    latch_rst_high: 1'b1,
    outreg_en: 1'b0,
    prio: PRIO_RSTREG,
    outreg_rst_high: 1'b1
  };

  // Widest permitted ratio between the two port widths
  localparam int MAX_RATIO = 32;
  // Value that latch and output register take on reset or set/reset
  localparam logic RESET_BIT = 1'b0;
  // Latch and output register stages, in clock edges
  localparam int LATCH_LAT = 1;
  localparam int OUTREG_LAT = 1;

endpackage

// [tb/fabric_driver.sv]
// Purpose: Fabric logic standing in front of the memory port.
// Assumes: Enable and resets active high, rising active edge.
// Notes: Bench calls send at falling edges only.
`timescale 1ns/100ps
`default_nettype none
module fabric_driver (
  // Request
  output logic port_en,
  output logic wr_en,
  output logic [5:0] addr,
  output logic [7:0] wr_data,
  // Output stage controls
  output logic latch_rst,
  output logic outreg_ce,
  output logic outreg_rst
);
  // Idle with the port disabled
  initial begin
    {port_en, wr_en, addr, wr_data, latch_rst, outreg_ce, outreg_rst} = '0;
  end
  // Whole request changes at once, held to the next falling edge
  task send(input logic [18:0] v);
    {port_en, wr_en, addr, wr_data, latch_rst, outreg_ce, outreg_rst} = v;
  endtask
endmodule
`default_nettype wire

// [tb/test_dual_port_bram_port_b.sv]
// Purpose: Self-checking bench for the Port B memory port.
// Assumes: Default and one registered inverted setup, 32x16 on Port A.
// Notes: Memory is filled first since it powers up unknown.
`timescale 1ns/100ps
`default_nettype none
module test_dual_port_bram_port_b;
  import bram_port_b_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic port_en, wr_en, latch_rst, outreg_ce, outreg_rst;
  logic [5:0] addr;
  logic [7:0] wr_data, rd_data;
  logic [31:0] r;
  logic [7:0] mem [64];
  logic [7:0] exp_rd = 8'h00;
  logic [7:0] rd_reg;
  logic [7:0] latch2 = 8'h00;
  logic [7:0] exp_reg = 8'h00;
  localparam port_cfg_t CFG_REG = '{access: ACC_READ_WRITE, wmode: WM_WRITE_FIRST,
    clk_rising: 1'b1, pe_high: 1'b0, latch_rst_high: 1'b0, outreg_en: 1'b1,
    prio: PRIO_REGCE, outreg_rst_high: 1'b0};
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 77545;
  always #5 ref_clk = ~ref_clk;
  fabric_driver fab (.port_en(port_en), .wr_en(wr_en), .addr(addr), .wr_data(wr_data),
    .latch_rst(latch_rst), .outreg_ce(outreg_ce), .outreg_rst(outreg_rst));
  bram_port_b #(.WIDTH_A(32), .DEPTH_A(16), .WIDTH_B(8), .CFG(CFG_DEFAULT)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .port_en(port_en), .wr_en(wr_en),
    .addr(addr), .wr_data(wr_data), .latch_rst(latch_rst), .outreg_ce(outreg_ce),
    .outreg_rst(outreg_rst), .rd_data(rd_data));
  // Registered, write-first, enable priority, polarities inverted
  bram_port_b #(.WIDTH_A(32), .DEPTH_A(16), .WIDTH_B(8), .CFG(CFG_REG)) uut2 (
    .ref_clk(ref_clk), .reset_n(reset_n), .port_en(!port_en), .wr_en(wr_en),
    .addr(addr), .wr_data(wr_data), .latch_rst(!latch_rst), .outreg_ce(outreg_ce),
    .outreg_rst(!outreg_rst), .rd_data(rd_reg));
  task check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task conclude;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One cycle: drive, model the rising edge, compare once settled
  task step(input logic [31:0] v);
    @(negedge ref_clk);
    fab.send(v[18:0]);
    @(posedge ref_clk);
    if (v[1]) exp_reg = v[0] ? 8'h00 : latch2;
    if (v[2]) latch2 = 8'h00;
    else if (v[18] && !v[17]) latch2 = mem[v[16:11]];
    else if (v[18]) latch2 = v[10:3];
    if (v[2]) exp_rd = 8'h00;
    else if (v[18] && !v[17]) exp_rd = mem[v[16:11]];
    if (v[18] && v[17]) mem[v[16:11]] = v[10:3];
    #1;
    check(rd_data, exp_rd);
    check(rd_reg, exp_reg);
  endtask
  // Hang guard, well above the planned run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    check(rd_data, 8'h00);
    check(rd_reg, 8'h00);
    // Fill every word reachable at the port width
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      step({13'h0, 2'b11, i[5:0], r[7:0], 3'b000});
    end
    $display("fill done");
    // Boundary reads back to back, then write and read the top word
    step({13'h0, 2'b10, 6'h00, 8'h00, 3'b010});
    step({13'h0, 2'b10, 6'h3f, 8'h00, 3'b010});
    step({13'h0, 2'b11, 6'h3f, 8'ha5, 3'b010});
    step({13'h0, 2'b10, 6'h3f, 8'h00, 3'b100});
    step({13'h0, 2'b10, 6'h3f, 8'h00, 3'b011});
    step({13'h0, 2'b10, 6'h3f, 8'h00, 3'b010});
    $display("boundary done");
    // Random reads, writes, idle cycles, rare latch resets
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      r[18] = r[18] | r[19];
      r[2] = (r[25:22] == 4'h0);
      step(r);
    end
    $display("random done");
    conclude();
  end
endmodule
`default_nettype wire
